// file: src/uvr_buf_if.sv
// fill and drain handshake bundle between the host and its read buffer
`timescale 1ns/1ns

interface uvr_buf_if #(parameter int W = 8);
    logic         fill_valid;
    logic         fill_ready;
    logic [W-1:0] fill_data;
    logic         drain_valid;
    logic         drain_ready;
    logic [W-1:0] drain_data;

    modport ctl (
        output fill_valid, fill_data, drain_ready,
        input  fill_ready, drain_valid, drain_data
    );
    modport store (
        input  fill_valid, fill_data, drain_ready,
        output fill_ready, drain_valid, drain_data
    );
endinterface

// file: src/uvr_defs.svh
// request encodings, link codes and field positions for the vendor host
`ifndef UVR_DEFS_SVH
`define UVR_DEFS_SVH

// setup request type and request code bytes
`define UVR_RT_MEM_WR   8'h40
`define UVR_RQ_MEM_WR   8'h03
`define UVR_RT_MEM_RD   8'hC0
`define UVR_RQ_MEM_RD   8'h04
`define UVR_RT_SWAP     8'h41
`define UVR_RQ_SWAP     8'h90

// upper nibble of the value low byte for port swap and secondary hub
`define UVR_VAL_SWAP_HI 4'h3
`define UVR_VAL_SEC_HI  4'h5

// legal downstream port codes
`define UVR_PORT_MIN    4'h1
`define UVR_PORT_MAX    4'h4

// index of the last setup byte (eight bytes per setup packet)
`define UVR_SETUP_LAST  3'h7

// setup byte positions of the value, index and length fields
`define UVR_POS_VAL_LO  3'h2
`define UVR_POS_IDX_LO  3'h4
`define UVR_POS_LEN_LO  3'h6

// answer codes on the receive side of the link
`define UVR_RX_DATA     2'h0
`define UVR_RX_ZLP      2'h1
`define UVR_RX_ACK      2'h2
`define UVR_RX_STALL    2'h3

`endif

// file: src/uvr_pkg.sv
// types shared by the vendor request host, its bench and the device model
package uvr_pkg;

    // kind of control transfer the user asks for
    typedef enum logic [1:0] {
        UVR_MEM_WRITE,
        UVR_MEM_READ,
        UVR_PORT_SWAP,
        UVR_SEC_HUB
    } uvr_cmd_type;

    // packet kind placed on the transmit side of the link
    typedef enum logic [1:0] {
        UVR_TX_SETUP,
        UVR_TX_OUT,
        UVR_TX_IN
    } uvr_tx_type;

    // transfer sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SETUP_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_TOKEN,
        ST_RD_DATA,
        ST_STAT_IN,
        ST_STAT_OUT,
        ST_STAT_WAIT
    } uvr_state_type;

endpackage

// file: src/uvr_read_buffer.sv
// small ring buffer holding read bytes until the user takes them
`timescale 1ns/1ns

module uvr_read_buffer #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  logic   clk_in,
    input  logic   reset_in,
    input  logic   ce_in,
    uvr_buf_if.store bif
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    // ==========================================================
    // parameter checks
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("buffer depth must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   count_ff;
    logic          push;
    logic          pop;

    // ==========================================================
    // handshakes, gated by the clock enable so nothing is lost
    assign bif.fill_ready  = ce_in && (count_ff != FULL);
    assign bif.drain_valid = (count_ff != '0);
    assign bif.drain_data  = mem_ff[rd_ptr_ff];
    assign push            = bif.fill_valid && bif.fill_ready;
    assign pop             = ce_in && bif.drain_valid && bif.drain_ready;

    // storage array, written on push
    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem_ff[wr_ptr_ff] <= bif.fill_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (ce_in) begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // uvr_read_buffer

// file: src/uvr_vendor_host.sv
// host side sequencer for vendor control requests to the feature controller
`timescale 1ns/1ns
`include "uvr_defs.svh"

module uvr_vendor_host
    import uvr_pkg::*;
#(
    parameter int ADDR_W    = 32,
    parameter int BUF_DEPTH = 2
) (
    input  logic        clk_in,
    input  logic        reset_in,
    input  logic        ce_in,
    input  logic        cmd_valid_in,
    output logic        cmd_ready_out,
    input  uvr_cmd_type cmd_kind_in,
    input  logic [31:0] cmd_addr_in,
    input  logic [15:0] cmd_len_in,
    input  logic [3:0]  cmd_port_in,
    input  logic        wr_valid_in,
    output logic        wr_ready_out,
    input  logic [7:0]  wr_byte_in,
    output logic        rd_valid_out,
    input  logic        rd_ready_in,
    output logic [7:0]  rd_byte_out,
    output logic        done_out,
    output logic        error_out,
    output logic [3:0]  swap_port_out,
    output logic [3:0]  sec_port_out,
    output logic        tx_valid_out,
    output uvr_tx_type  tx_kind_out,
    output logic [7:0]  tx_byte_out,
    output logic        tx_last_out,
    input  logic        rx_valid_in,
    input  logic [1:0]  rx_code_in,
    input  logic [7:0]  rx_byte_in
);
    // ==========================================================
    // parameter checks
    generate
        if (ADDR_W != 32) begin : g_bad_addr
            $error("target address width must be 32");
        end
    endgenerate

    uvr_state_type state_ff, nxt_state;
    uvr_cmd_type   kind_ff;
    logic [31:0]   addr_ff;
    logic [15:0]   len_ff;
    logic [15:0]   cnt_ff;
    logic [3:0]    port_ff;
    logic [2:0]    idx_ff;
    logic          rx_valid_s1_ff, rx_valid_s2_ff;
    logic [1:0]    rx_code_s1_ff, rx_code_s2_ff;
    logic [7:0]    rx_byte_s1_ff, rx_byte_s2_ff;
    logic          cmd_take, port_bad, go, wr_take, tok_rd;
    logic          rx_ack, rx_stall, rx_zlp, rx_data;
    logic          fail, finish;

    uvr_buf_if #(.W(8)) bif ();

    // ==========================================================
    // helper functions
    function automatic logic is_mem(input uvr_cmd_type k);
        return (k == UVR_MEM_WRITE) || (k == UVR_MEM_READ);
    endfunction

    function automatic logic port_ok(input logic [3:0] p);
        return (p >= `UVR_PORT_MIN) && (p <= `UVR_PORT_MAX);
    endfunction

    // setup packet byte i, words sent low byte first
    function automatic logic [7:0] setup_byte(input uvr_cmd_type k,
        input logic [2:0] i, input logic [31:0] a,
        input logic [15:0] l, input logic [3:0] p);
        logic [7:0]  rt;
        logic [7:0]  rq;
        logic [15:0] wv;
        logic [15:0] wi;
        logic [15:0] wl;
        rt = (k == UVR_MEM_WRITE) ? `UVR_RT_MEM_WR :
             (k == UVR_MEM_READ)  ? `UVR_RT_MEM_RD : `UVR_RT_SWAP;
        rq = (k == UVR_MEM_WRITE) ? `UVR_RQ_MEM_WR :
             (k == UVR_MEM_READ)  ? `UVR_RQ_MEM_RD : `UVR_RQ_SWAP;
        wv = is_mem(k) ? a[15:0] : {8'h00, (k == UVR_PORT_SWAP) ?
             `UVR_VAL_SWAP_HI : `UVR_VAL_SEC_HI, p};
        wi = is_mem(k) ? a[31:16] : 16'h0000;
        wl = is_mem(k) ? l : 16'h0000;
        case (i)
            3'h0: return rt;
            3'h1: return rq;
            3'h2: return wv[7:0];
            3'h3: return wv[15:8];
            3'h4: return wi[7:0];
            3'h5: return wi[15:8];
            3'h6: return wl[7:0];
            default: return wl[15:8];
        endcase
    endfunction

    // ==========================================================
    // two-stage capture of the link answer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_valid_s1_ff <= 1'b0;
            rx_valid_s2_ff <= 1'b0;
            rx_code_s1_ff  <= 2'h0;
            rx_code_s2_ff  <= 2'h0;
            rx_byte_s1_ff  <= 8'h00;
            rx_byte_s2_ff  <= 8'h00;
        end else if (ce_in) begin
            rx_valid_s1_ff <= rx_valid_in;
            rx_code_s1_ff  <= rx_code_in;
            rx_byte_s1_ff  <= rx_byte_in;
            rx_valid_s2_ff <= rx_valid_s1_ff;
            rx_code_s2_ff  <= rx_code_s1_ff;
            rx_byte_s2_ff  <= rx_byte_s1_ff;
        end
    end

    // answer decode
    assign rx_ack   = rx_valid_s2_ff && (rx_code_s2_ff == `UVR_RX_ACK);
    assign rx_stall = rx_valid_s2_ff && (rx_code_s2_ff == `UVR_RX_STALL);
    assign rx_zlp   = rx_valid_s2_ff && (rx_code_s2_ff == `UVR_RX_ZLP);
    assign rx_data  = rx_valid_s2_ff && (rx_code_s2_ff == `UVR_RX_DATA);

    // ==========================================================
    // user handshakes
    assign cmd_ready_out = ce_in && (state_ff == ST_IDLE);
    assign cmd_take      = cmd_ready_out && cmd_valid_in;
    assign port_bad = !is_mem(cmd_kind_in) && !port_ok(cmd_port_in);
    assign go       = cmd_take && !port_bad;
    assign wr_ready_out = ce_in && (state_ff == ST_WR_DATA);
    assign wr_take      = wr_ready_out && wr_valid_in;
    // one IN token per byte, only with buffer room
    assign tok_rd       = (state_ff == ST_RD_TOKEN) && bif.fill_ready;

    // read bytes into the buffer, user drains it
    assign bif.fill_valid  = ce_in && (state_ff == ST_RD_DATA) && rx_data;
    assign bif.fill_data   = rx_byte_s2_ff;
    assign bif.drain_ready = rd_ready_in;
    assign rd_valid_out    = bif.drain_valid;
    assign rd_byte_out     = bif.drain_data;

    uvr_read_buffer #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .bif      (bif)
    );

    // completion and failure events
    assign fail = (cmd_take && port_bad)
        || (rx_stall && (state_ff == ST_SETUP_ACK || state_ff == ST_WR_ACK
            || state_ff == ST_RD_DATA || state_ff == ST_STAT_WAIT))
        || (rx_zlp && state_ff == ST_RD_DATA);
    assign finish = (state_ff == ST_STAT_WAIT) && rx_zlp;

    // ==========================================================
    // transfer sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (go) begin
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (idx_ff == `UVR_SETUP_LAST) begin
                    nxt_state = ST_SETUP_ACK;
                end
            end
            ST_SETUP_ACK: begin
                if (rx_stall) begin
                    nxt_state = ST_IDLE;
                end else if (rx_ack) begin
                    // no data stage for swap requests
                    if (kind_ff == UVR_MEM_WRITE) begin
                        nxt_state = (len_ff == 16'h0000) ? ST_STAT_IN
                                                         : ST_WR_DATA;
                    end else if (kind_ff == UVR_MEM_READ) begin
                        nxt_state = (len_ff == 16'h0000) ? ST_STAT_OUT
                                                         : ST_RD_TOKEN;
                    end else begin
                        nxt_state = ST_STAT_IN;
                    end
                end
            end
            ST_WR_DATA: begin
                if (wr_take && cnt_ff == 16'h0001) begin
                    nxt_state = ST_WR_ACK;
                end
            end
            ST_WR_ACK: begin
                if (rx_stall) begin
                    nxt_state = ST_IDLE;
                end else if (rx_ack) begin
                    nxt_state = ST_STAT_IN;
                end
            end
            ST_RD_TOKEN: begin
                if (tok_rd) begin
                    nxt_state = ST_RD_DATA;
                end
            end
            ST_RD_DATA: begin
                if (rx_stall || rx_zlp) begin
                    nxt_state = ST_IDLE;
                end else if (rx_data) begin
                    // OUT status after the last byte
                    nxt_state = (cnt_ff == 16'h0001) ? ST_STAT_OUT
                                                     : ST_RD_TOKEN;
                end
            end
            ST_STAT_IN:  nxt_state = ST_STAT_WAIT;
            ST_STAT_OUT: nxt_state = ST_STAT_WAIT;
            ST_STAT_WAIT: begin
                if (rx_stall || rx_zlp) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // state, setup index and byte count
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff <= ST_IDLE;
            idx_ff   <= 3'h0;
            cnt_ff   <= 16'h0000;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            if (go) begin
                idx_ff <= 3'h0;
                cnt_ff <= cmd_len_in;
            end else if (state_ff == ST_SETUP) begin
                idx_ff <= idx_ff + 3'h1;
            end else if (wr_take || bif.fill_valid) begin
                // count down bytes of the data stage
                cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end

    // captured request
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            kind_ff <= UVR_MEM_WRITE;
            addr_ff <= 32'h0000_0000;
            len_ff  <= 16'h0000;
            port_ff <= 4'h0;
        end else if (ce_in && go) begin
            kind_ff <= cmd_kind_in;
            addr_ff <= cmd_addr_in;
            len_ff  <= cmd_len_in;
            port_ff <= cmd_port_in;
        end
    end

    // link carries endpoint 0 traffic only
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_valid_out <= 1'b0;
            tx_kind_out  <= UVR_TX_SETUP;
            tx_byte_out  <= 8'h00;
            tx_last_out  <= 1'b0;
        end else if (ce_in) begin
            tx_valid_out <= (state_ff == ST_SETUP) || wr_take || tok_rd
                || (state_ff == ST_STAT_IN) || (state_ff == ST_STAT_OUT);
            tx_byte_out  <= 8'h00;
            tx_last_out  <= 1'b1;
            tx_kind_out  <= UVR_TX_IN;
            if (state_ff == ST_SETUP) begin
                tx_kind_out <= UVR_TX_SETUP;
                tx_byte_out <= setup_byte(kind_ff, idx_ff, addr_ff,
                                          len_ff, port_ff);
                tx_last_out <= (idx_ff == `UVR_SETUP_LAST);
            end else if (state_ff == ST_WR_DATA) begin
                tx_kind_out <= UVR_TX_OUT;
                tx_byte_out <= wr_byte_in;
                tx_last_out <= (cnt_ff == 16'h0001);
            end else if (state_ff == ST_STAT_OUT) begin
                tx_kind_out <= UVR_TX_OUT;
            end
        end
    end

    // completion report
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            done_out  <= 1'b0;
            error_out <= 1'b0;
        end else if (ce_in) begin
            done_out  <= fail || finish;
            error_out <= fail;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            swap_port_out <= 4'h0;
            sec_port_out  <= 4'h0;
        end else if (ce_in && finish) begin
            if (kind_ff == UVR_PORT_SWAP) begin
                swap_port_out <= port_ff;
            end
            if (kind_ff == UVR_SEC_HUB) begin
                sec_port_out <= port_ff;
            end
        end
    end

    // ==========================================================
    // checks on the generated packets
    default clocking cb @(posedge clk_in iff ce_in);
    endclocking
    default disable iff (reset_in);

    function automatic logic at_setup(input logic [2:0] i);
        return (state_ff == ST_SETUP) && (idx_ff == i);
    endfunction

    sequence s_addr_le;
        tx_byte_out == addr_ff[7:0] ##1 tx_byte_out == addr_ff[15:8]
        ##1 tx_byte_out == addr_ff[23:16] ##1 tx_byte_out == addr_ff[31:24];
    endsequence
    sequence s_status_out;
        tx_valid_out && tx_kind_out == UVR_TX_OUT && tx_last_out;
    endsequence

    property p_wr_code;
        at_setup(3'h0) && kind_ff == UVR_MEM_WRITE |=>
            tx_byte_out == `UVR_RT_MEM_WR ##1 tx_byte_out == `UVR_RQ_MEM_WR;
    endproperty
    a_wr_code: assert property (p_wr_code)
        else $error("memory write type or code wrong");
    property p_rd_code;
        at_setup(3'h0) && kind_ff == UVR_MEM_READ |=>
            tx_byte_out == `UVR_RT_MEM_RD ##1 tx_byte_out == `UVR_RQ_MEM_RD;
    endproperty
    a_rd_code: assert property (p_rd_code)
        else $error("memory read type or code wrong");
    property p_addr;
        at_setup(`UVR_POS_VAL_LO) && is_mem(kind_ff) |=> s_addr_le;
    endproperty
    a_addr: assert property (p_addr)
        else $error("target address bytes out of order");
    property p_len;
        at_setup(`UVR_POS_LEN_LO) && is_mem(kind_ff) |=>
            tx_byte_out == len_ff[7:0]
            ##1 tx_byte_out == len_ff[15:8] && tx_last_out;
    endproperty
    a_len: assert property (p_len)
        else $error("length field wrong");
    property p_swap_zero;
        at_setup(`UVR_POS_IDX_LO) && !is_mem(kind_ff) |=>
            (tx_byte_out == 8'h00) [*4];
    endproperty
    a_swap_zero: assert property (p_swap_zero)
        else $error("swap index or length not zero");
    property p_swap_val;
        at_setup(`UVR_POS_VAL_LO) && kind_ff == UVR_PORT_SWAP |=>
            tx_byte_out == {`UVR_VAL_SWAP_HI, port_ff} && port_ok(port_ff);
    endproperty
    a_swap_val: assert property (p_swap_val)
        else $error("swap value wrong");
    property p_sec_val;
        at_setup(`UVR_POS_VAL_LO) && kind_ff == UVR_SEC_HUB |=>
            tx_byte_out == {`UVR_VAL_SEC_HI, port_ff} && port_ok(port_ff);
    endproperty
    a_sec_val: assert property (p_sec_val)
        else $error("secondary hub value wrong");
    property p_rd_status;
        state_ff == ST_RD_DATA && rx_data && cnt_ff == 16'h0001 |=>
            state_ff == ST_STAT_OUT ##1 s_status_out;
    endproperty
    a_rd_status: assert property (p_rd_status)
        else $error("read not closed by OUT status");
    property p_bad_port;
        cmd_take && port_bad |=> done_out && error_out && !tx_valid_out;
    endproperty
    a_bad_port: assert property (p_bad_port)
        else $error("bad port code not refused");
endmodule // uvr_vendor_host

// file: test/tb_usb_vendor_request_decoder.sv
// self-checking bench for the vendor request host
`timescale 1ns/1ns

module tb_usb_vendor_request_decoder import uvr_pkg::*;;
    // ==========================================
    // stimulus, model and checks
    logic        clk_in, reset_in, cmd_valid_in, wr_valid_in, rd_ready_in;
    logic        ce, slow, stall, cmd_ready_out, wr_ready_out, rd_valid_out;
    logic        done_out, error_out, tx_valid_out, tx_last_out, rx_valid_in;
    uvr_cmd_type cmd_kind_in;
    uvr_tx_type  tx_kind_out;
    logic [31:0] cmd_addr_in;
    logic [15:0] cmd_len_in;
    logic [3:0]  cmd_port_in, swap_port_out, sec_port_out;
    logic [7:0]  wr_byte_in, rd_byte_out, tx_byte_out, rx_byte_in;
    logic [1:0]  rx_code_in;
    int          bad_count, samples_checked;
    logic [10:0] txq [$];
    logic [10:0] eq [$];
    logic [7:0]  rdq [$];
    logic [7:0]  wd [3] = '{8'h78, 8'h56, 8'h9A};

    uvr_vendor_host dut_u (.clk_in, .reset_in, .ce_in(ce), .cmd_valid_in,
        .cmd_ready_out, .cmd_kind_in, .cmd_addr_in, .cmd_len_in, .cmd_port_in,
        .wr_valid_in, .wr_ready_out, .wr_byte_in, .rd_valid_out, .rd_ready_in,
        .rd_byte_out, .done_out, .error_out, .swap_port_out, .sec_port_out,
        .tx_valid_out, .tx_kind_out, .tx_byte_out, .tx_last_out, .rx_valid_in,
        .rx_code_in, .rx_byte_in);
    uvr_dev_model dev_u (.clk_in, .reset_in, .slow_in(slow), .stall_in(stall),
        .tx_valid_in(tx_valid_out), .tx_kind_in(tx_kind_out),
        .tx_byte_in(tx_byte_out), .tx_last_in(tx_last_out),
        .rx_valid_out(rx_valid_in), .rx_code_out(rx_code_in),
        .rx_byte_out(rx_byte_in));

    // clock and record of every sent byte and token
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (tx_valid_out === 1'h1) txq.push_back({tx_last_out, tx_kind_out,
            tx_byte_out});
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic exp_setup(input logic [7:0] t, input logic [7:0] c,
            input logic [15:0] v, input logic [15:0] x, input logic [15:0] l);
        logic [7:0] b [8];
        b = '{t, c, v[7:0], v[15:8], x[7:0], x[15:8], l[7:0], l[15:8]};
        eq.delete();
        foreach (b[i]) eq.push_back({i == 7, UVR_TX_SETUP, b[i]});
    endtask

    task automatic chk_tx();
        chk(txq.size(), eq.size());
        foreach (eq[i]) chk(txq[i], eq[i]);
    endtask

    // one whole transfer; write bytes with gaps, reader stalling
    task automatic run(input uvr_cmd_type k, input logic [31:0] a,
            input logic [15:0] l, input logic [3:0] p, output logic e);
        int   n;
        int   wi;
        logic dn, ct, wt;
        wi = 0;
        dn = 1'h0;
        e = 1'h1;
        txq.delete();
        rdq.delete();
        // only the requested transfer goes out
        cmd_valid_in = 1'h1;
        cmd_kind_in = k;
        cmd_addr_in = a;
        cmd_len_in = l;
        cmd_port_in = p;
        for (n = 0; n < 3000 && !(dn && rd_valid_out !== 1'h1); n++) begin
            #1;
            ct = cmd_valid_in && cmd_ready_out;
            wt = wr_valid_in && wr_ready_out;
            if (rd_valid_out && rd_ready_in) rdq.push_back(rd_byte_out);
            @(negedge clk_in);
            if (ct) cmd_valid_in = 1'h0;
            wi += wt;
            if (done_out === 1'h1) begin
                dn = 1'h1;
                e = error_out;
            end
            wr_valid_in = k == UVR_MEM_WRITE && wi < l && !wt;
            wr_byte_in = wd[wi];
            rd_ready_in = n[1];
        end
        wr_valid_in = 1'h0;
        if (!dn) begin
            bad_count++;
            $display("[ERR] %0t transfer hung", $time);
            finish_test();
        end
    endtask

    task automatic t_mem();
        logic e;
        run(UVR_MEM_WRITE, 32'hBF803002, 16'h0003, 4'h0, e);
        chk(e, 1'h0);
        exp_setup(8'h40, 8'h03, 16'h3002, 16'hBF80, 16'h0003);
        foreach (wd[i]) eq.push_back({i == 2, UVR_TX_OUT, wd[i]});
        eq.push_back({1'h1, UVR_TX_IN, 8'h00});
        chk_tx();
        slow = 1'h1;
        run(UVR_MEM_READ, 32'hBF803002, 16'h0003, 4'h0, e);
        slow = 1'h0;
        chk(e, 1'h0);
        exp_setup(8'hC0, 8'h04, 16'h3002, 16'hBF80, 16'h0003);
        repeat (3) eq.push_back({1'h1, UVR_TX_IN, 8'h00});
        eq.push_back({1'h1, UVR_TX_OUT, 8'h00});
        chk_tx();
        chk(rdq.size(), 3);
        foreach (wd[i]) chk(rdq[i], wd[i]);
    endtask

    task automatic t_swap();
        logic e;
        for (int p = 1; p <= 5; p++) begin
            run(p < 5 ? UVR_PORT_SWAP : UVR_SEC_HUB, 32'h0, 16'h0,
                p < 5 ? p[3:0] : 4'h1, e);
            chk(e, 1'h0);
            exp_setup(8'h41, 8'h90, p < 5 ? {12'h003, p[3:0]} : 16'h0051,
                16'h0000, 16'h0000);
            eq.push_back({1'h1, UVR_TX_IN, 8'h00});
            chk_tx();
        end
        // frozen by the clock enable, sessions still held
        ce = 1'h0;
        repeat (300) @(negedge clk_in);
        chk(cmd_ready_out, 1'h0);
        ce = 1'h1;
        repeat (2) @(negedge clk_in);
        chk(swap_port_out, 4);
        chk(sec_port_out, 1);
    endtask

    task automatic t_refuse();
        logic e;
        foreach (wd[i]) begin
            run(UVR_PORT_SWAP, 32'h0, 16'h0, 4'h5 * i[3:0], e);
            chk(e, 1'h1);
            chk(txq.size(), 0);
        end
        stall = 1'h1;
        run(UVR_MEM_WRITE, 32'hBF803002, 16'h0003, 4'h0, e);
        stall = 1'h0;
        chk(e, 1'h1);
        exp_setup(8'h40, 8'h03, 16'h3002, 16'hBF80, 16'h0003);
        chk_tx();
    endtask

    // reset, then the scenarios in turn
    initial begin
        clk_in = 1'h0;
        reset_in = 1'h1;
        {cmd_valid_in, wr_valid_in, rd_ready_in, slow, stall} = 5'h00;
        ce = 1'h1;
        cmd_kind_in = UVR_MEM_WRITE;
        {cmd_addr_in, cmd_len_in, cmd_port_in, wr_byte_in} = 60'h0;
        repeat (16) @(negedge clk_in);
        reset_in = 1'h0;
        t_mem();
        t_swap();
        t_refuse();
        finish_test();
    end
endmodule // tb_usb_vendor_request_decoder

// file: test/uvr_dev_model.sv
// device model answering vendor control transfers
`timescale 1ns/1ns
`include "uvr_defs.svh"

module uvr_dev_model
    import uvr_pkg::*;
(
    input  logic       clk_in,
    input  logic       reset_in,
    input  logic       slow_in,
    input  logic       stall_in,
    input  logic       tx_valid_in,
    input  uvr_tx_type tx_kind_in,
    input  logic [7:0] tx_byte_in,
    input  logic       tx_last_in,
    output logic       rx_valid_out,
    output logic [1:0] rx_code_out,
    output logic [7:0] rx_byte_out
);
    // ==========================================
    // request decode and answers
    logic [7:0]  mem_ff [16];
    logic [7:0]  set_ff [8];
    logic [2:0]  si_ff;
    logic [3:0]  cnt_ff, base_ff, wait_ff;
    logic [15:0] len_ff, val_w, len_w;
    logic        rd_ff, pend_ff, ok_w;
    logic [9:0]  ans_ff;

    // setup fields, low byte first
    assign val_w = {set_ff[3], set_ff[2]};
    assign len_w = {tx_byte_in, set_ff[6]};
    assign ok_w = {set_ff[0], set_ff[1]} inside {16'h4003, 16'hC004}
        || ({set_ff[0], set_ff[1]} == 16'h4190
        && {set_ff[5], set_ff[4]} == 16'h0000 && len_w == 16'h0000
        && val_w[15:4] inside {12'h003, 12'h005}
        && val_w[3:0] inside {[4'h1:4'h4]});

    task automatic answer(input logic [1:0] c, input logic [7:0] d);
        pend_ff <= 1'h1;
        ans_ff  <= {c, d};
        wait_ff <= slow_in ? 4'h9 : 4'h0;
    endtask

    // one answer in flight; idle answer lines keep changing
    always @(posedge clk_in) begin
        rx_valid_out <= 1'h0;
        rx_code_out  <= rx_code_out + 2'h1;
        rx_byte_out  <= ~rx_byte_out;
        if (pend_ff) begin
            wait_ff <= wait_ff - 4'h1;
        end
        if (pend_ff && wait_ff == 4'h0) begin
            pend_ff      <= 1'h0;
            rx_valid_out <= 1'h1;
            {rx_code_out, rx_byte_out} <= ans_ff;
        end
        if (tx_valid_in && tx_kind_in == UVR_TX_SETUP) begin
            set_ff[si_ff] <= tx_byte_in;
            si_ff         <= si_ff + 3'h1;
            if (tx_last_in) begin
                rd_ff   <= set_ff[0] == `UVR_RT_MEM_RD;
                base_ff <= set_ff[2][3:0];
                len_ff  <= len_w;
                cnt_ff  <= 4'h0;
                answer(ok_w && !stall_in ? `UVR_RX_ACK : `UVR_RX_STALL, 8'h00);
            end
        end
        if (tx_valid_in && tx_kind_in == UVR_TX_OUT && !rd_ff) begin
            mem_ff[base_ff + cnt_ff] <= tx_byte_in;
            cnt_ff <= cnt_ff + 4'h1;
            if (tx_last_in) answer(`UVR_RX_ACK, 8'h00);
        end
        if (tx_valid_in && tx_kind_in == UVR_TX_IN && rd_ff
            && cnt_ff < len_ff) begin
            answer(`UVR_RX_DATA, mem_ff[base_ff + cnt_ff]);
            cnt_ff <= cnt_ff + 4'h1;
        end
        if (tx_valid_in && (tx_kind_in == UVR_TX_OUT ? rd_ff
            : tx_kind_in == UVR_TX_IN && !(rd_ff && cnt_ff < len_ff))) begin
            answer(`UVR_RX_ZLP, 8'h00);
        end
        if (reset_in) begin
            si_ff       <= 3'h0;
            pend_ff     <= 1'h0;
            rx_code_out <= 2'h0;
            rx_byte_out <= 8'h00;
        end
    end
endmodule // uvr_dev_model
